// *** design/dpot_top.sv ***
// Dual potentiometer serial command port with wiper and stored registers
`timescale 1ns/10ps
`include "dpot_defs.svh"

// Behaviour
// - Write-only port with select, serial clock and data inputs; no read-back.
// - While select is low, one data bit shifts in per serial clock rise.
// - Write commands 00 and 01 take sixteen clock edges before select rises.
// - Copy commands 10 and 11 take eight or sixteen edges; extra data ignored.
// - Select rising executes the frame and idles the port until select falls.
// - Edges 1-2 zero, 3-4 command, 5-6 zero, 7-8 channel, 9-16 data MSB first.
// - Channel 01 is A, 10 is B, 11 is both, for every command.
// - Command 00 loads data into addressed wipers, stored values untouched.
// - Code 00 is the low-end tap, ff the high-end tap, linear between.
// - At power-up each stored value is copied into its wiper.
// - Command 01 loads data into addressed stored registers, wipers untouched.
// - Command 10 copies addressed wipers into their stored registers.
// - Command 11 copies addressed stored registers into their wipers.
// - A stored-register write keeps the device busy for 20 ms.
// - Power-up recall completes within 100 us.
module dpot_top
    import dpot_pkg::*;
#(
    parameter int STORE_BUSY_CYCLES = `DPOT_STORE_BUSY_CYC
)
(
    // System clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Serial command pins
    input wire logic sclk,
    input wire logic select_n,
    input wire logic serial_din,
    // Wiper tap selects, 8'h00 at the low end
    output logic [7:0] wiper_position_a,
    output logic [7:0] wiper_position_b,
    // Status
    output logic store_busy,
    output logic recall_done
);

    localparam int RECALL_MAX_CYC = `DPOT_RECALL_MAX_CYC;

    dpot_raw_frame_t raw_frame;
    dpot_raw_frame_t raw_sys;
    dpot_frame_t frame;
    dpot_state_t state_reg;
    dpot_state_t state_next;
    logic select_sync;
    logic select_prev_reg;
    logic frame_end;
    logic long_frame;
    logic len_ok;
    logic nv_touch;
    logic exec_ok;
    logic hit_a;
    logic hit_b;
    logic [7:0] stored_position_a;
    logic [7:0] stored_position_b;
    logic [`DPOT_BUSY_W-1:0] busy_cnt_reg;

    // Link-side shifter, three inputs only, no way back to the host
    dpot_shift u_shift (
        .sclk(sclk),
        .select_n(select_n),
        .serial_din(serial_din),
        .raw_frame(raw_frame)
    );

    // Select crosses as a level; it also serves as the handshake for the frame
    dpot_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sel_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(select_n),
        .sync_out(select_sync)
    );

    // Previous synchronised select for the rising edge
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            select_prev_reg <= 1'b1;
        else
            select_prev_reg <= select_sync;
    end

    // The frame words are quasi-static: the serial clock is stopped by the
    // time the synchronised select rise is seen, two cycles after the pin
    assign raw_sys = raw_frame;
    assign frame_end = select_sync & ~select_prev_reg;

    // Field extraction depends on frame length
    always_comb
    begin
        long_frame = raw_sys.edge_count == `DPOT_FRAME_LONG;
        if (long_frame)
        begin
            frame.command = dpot_cmd_t'(raw_sys.bits[`DPOT_L_CMD_LSB +: 2]);
            frame.channel_bit_high = raw_sys.bits[`DPOT_L_CHAN_LSB + 1];
            frame.channel_bit_low = raw_sys.bits[`DPOT_L_CHAN_LSB];
            frame.wiper_position_bits = raw_sys.bits[`DPOT_L_DATA_LSB +: 8];
        end
        else
        begin
            frame.command = dpot_cmd_t'(raw_sys.bits[`DPOT_S_CMD_LSB +: 2]);
            frame.channel_bit_high = raw_sys.bits[`DPOT_S_CHAN_LSB + 1];
            frame.channel_bit_low = raw_sys.bits[`DPOT_S_CHAN_LSB];
            frame.wiper_position_bits = 8'h00;
        end
    end

    // Length check: writes need 16, copies 8 or 16
    assign len_ok = long_frame
        || (raw_sys.edge_count == `DPOT_FRAME_SHORT && frame.command[1]);

    // Channel decode; 00 hits neither channel
    assign hit_a = frame.channel_bit_low;
    assign hit_b = frame.channel_bit_high;

    // Commands that write the stored registers
    assign nv_touch = frame.command == DPOT_CMD_WR_NONVOLATILE
        || frame.command == DPOT_CMD_COPY_TO_NONVOLATILE;

    // A store in progress refuses further stores but not wiper moves
    assign exec_ok = frame_end && len_ok && state_reg != ST_RECALL
        && !(state_reg == ST_STORE && nv_touch);

    // Wiper registers: recall after reset, then write or restore
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wiper_position_a <= `DPOT_WIPER_RESET;
            wiper_position_b <= `DPOT_WIPER_RESET;
        end
        else if (state_reg == ST_RECALL)
        begin
            wiper_position_a <= stored_position_a;
            wiper_position_b <= stored_position_b;
        end
        else if (exec_ok && frame.command == DPOT_CMD_WR_WIPER)
        begin
            if (hit_a)
                wiper_position_a <= frame.wiper_position_bits;
            if (hit_b)
                wiper_position_b <= frame.wiper_position_bits;
        end
        else if (exec_ok && frame.command == DPOT_CMD_COPY_TO_WIPER)
        begin
            if (hit_a)
                wiper_position_a <= stored_position_a;
            if (hit_b)
                wiper_position_b <= stored_position_b;
        end
    end

    // Stored registers; reset loads the factory stand-in values, not what was written
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stored_position_a <= `DPOT_STORED_INIT_A;
            stored_position_b <= `DPOT_STORED_INIT_B;
        end
        else if (exec_ok && frame.command == DPOT_CMD_WR_NONVOLATILE)
        begin
            if (hit_a)
                stored_position_a <= frame.wiper_position_bits;
            if (hit_b)
                stored_position_b <= frame.wiper_position_bits;
        end
        else if (exec_ok && frame.command == DPOT_CMD_COPY_TO_NONVOLATILE)
        begin
            if (hit_a)
                stored_position_a <= wiper_position_a;
            if (hit_b)
                stored_position_b <= wiper_position_b;
        end
    end

    // Controller next state
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RECALL:
                state_next = ST_READY;
            ST_READY:
                if (exec_ok && nv_touch && (hit_a || hit_b))
                    state_next = ST_STORE;
            ST_STORE:
                if (busy_cnt_reg == '0)
                    state_next = ST_READY;
        endcase
    end

    // Controller state
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            state_reg <= ST_RECALL;
        else
            state_reg <= state_next;
    end

    // Busy timer, loaded when a store starts
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            busy_cnt_reg <= '0;
        else if (state_reg == ST_READY && state_next == ST_STORE)
            busy_cnt_reg <= `DPOT_BUSY_W'(STORE_BUSY_CYCLES - 1);
        else if (busy_cnt_reg != '0)
            busy_cnt_reg <= busy_cnt_reg - `DPOT_BUSY_W'(1);
    end

    // Status outputs follow the state register
    assign store_busy = state_reg == ST_STORE;
    assign recall_done = state_reg != ST_RECALL;

    // Checking helpers: cycles since reset and busy length
    logic [11:0] boot_cnt_reg;
    logic [`DPOT_BUSY_W-1:0] busy_len_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            boot_cnt_reg <= '0;
        else if (boot_cnt_reg != 12'hfff)
            boot_cnt_reg <= boot_cnt_reg + 12'h001;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst || !store_busy)
            busy_len_reg <= '0;
        else
            busy_len_reg <= busy_len_reg + `DPOT_BUSY_W'(1);
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_RECALL_TIME: assert property (
        !recall_done |-> int'(boot_cnt_reg) < RECALL_MAX_CYC)
        else $error("power-up recall late");

    AST_RECALL_VALUE: assert property (
        $rose(recall_done) |-> wiper_position_a == stored_position_a
            && wiper_position_b == stored_position_b)
        else $error("wipers do not hold stored values after recall");

    AST_WIPER_WRITE: assert property (
        exec_ok && frame.command == DPOT_CMD_WR_WIPER && hit_a
        |=> wiper_position_a == $past(frame.wiper_position_bits)
            && $stable(stored_position_a) && $stable(stored_position_b))
        else $error("wiper write wrong");

    AST_NV_WRITE: assert property (
        exec_ok && frame.command == DPOT_CMD_WR_NONVOLATILE && hit_b
        |=> stored_position_b == $past(frame.wiper_position_bits)
            && $stable(wiper_position_a) && $stable(wiper_position_b))
        else $error("stored write wrong");

    AST_COPY_TO_NV: assert property (
        exec_ok && frame.command == DPOT_CMD_COPY_TO_NONVOLATILE && hit_a
        |=> stored_position_a == $past(wiper_position_a))
        else $error("wiper not copied to stored register");

    AST_COPY_TO_WIPER: assert property (
        exec_ok && frame.command == DPOT_CMD_COPY_TO_WIPER && hit_b
        |=> wiper_position_b == $past(stored_position_b))
        else $error("stored value not copied to wiper");

    AST_BAD_LENGTH: assert property (
        frame_end && !len_ok |=> $stable(wiper_position_a) && $stable(wiper_position_b)
            && $stable(stored_position_a) && $stable(stored_position_b))
        else $error("frame of wrong length changed a register");

    AST_NO_CHANNEL: assert property (
        frame_end && !hit_a && !hit_b |=> $stable(wiper_position_a)
            && $stable(wiper_position_b) && $stable(stored_position_a)
            && $stable(stored_position_b) && !$rose(store_busy))
        else $error("channel 00 changed a register");

    AST_BUSY_LENGTH: assert property (
        $fell(store_busy) |-> int'($past(busy_len_reg)) == STORE_BUSY_CYCLES - 1)
        else $error("store busy time wrong");

    AST_EXEC_ON_SELECT: assert property (
        !frame_end |=> $stable(wiper_position_a) || $past(state_reg) == ST_RECALL)
        else $error("wiper moved without select rising");

    COV_LONG_WRITE: cover property (exec_ok && long_frame
        && frame.command == DPOT_CMD_WR_WIPER && hit_a && hit_b);
    COV_SHORT_COPY: cover property (exec_ok && !long_frame);
    COV_STORE_DONE: cover property ($fell(store_busy));
    COV_STORE_REFUSED: cover property (frame_end && len_ok && store_busy && nv_touch);

endmodule : dpot_top

// *** design/dpot_defs.svh ***
// Constants for the dual potentiometer serial command port
`ifndef DPOT_DEFS_SVH
`define DPOT_DEFS_SVH

// System clock period
`define DPOT_CLK_PERIOD_NS 50

// Frame lengths in serial clock edges
`define DPOT_FRAME_LONG 5'd16
`define DPOT_FRAME_SHORT 5'd8
`define DPOT_EDGE_MAX 5'd17

// Field positions in a 16-edge frame (edge 1 lands in bit 15)
`define DPOT_L_CMD_LSB 12
`define DPOT_L_CHAN_LSB 8
`define DPOT_L_DATA_LSB 0

// Field positions in an 8-edge frame (edge 1 lands in bit 7)
`define DPOT_S_CMD_LSB 4
`define DPOT_S_CHAN_LSB 0

// Reset values; the stored pair stands in for the factory contents
`define DPOT_WIPER_RESET 8'h00
`define DPOT_STORED_INIT_A 8'h80
`define DPOT_STORED_INIT_B 8'h80

// Store busy time, a least figure, rounded up to cycles
`define DPOT_STORE_BUSY_MS 20
`define DPOT_STORE_BUSY_CYC \
    (((`DPOT_STORE_BUSY_MS * 1000000) + `DPOT_CLK_PERIOD_NS - 1) / `DPOT_CLK_PERIOD_NS)
`define DPOT_BUSY_W 19

// Power-up recall limit, a longest figure, rounded down to cycles
`define DPOT_RECALL_MAX_US 100
`define DPOT_RECALL_MAX_CYC ((`DPOT_RECALL_MAX_US * 1000) / `DPOT_CLK_PERIOD_NS)

`endif

// *** design/dpot_pkg.sv ***
// Types shared by the dual potentiometer serial command port
package dpot_pkg;

    // Command codes carried by the two command bits
    typedef enum logic [1:0] {
        DPOT_CMD_WR_WIPER = 2'h0,
        DPOT_CMD_WR_NONVOLATILE = 2'h1,
        DPOT_CMD_COPY_TO_NONVOLATILE = 2'h2,
        DPOT_CMD_COPY_TO_WIPER = 2'h3
    } dpot_cmd_t;

    // Controller states
    typedef enum logic [1:0] {
        ST_RECALL,
        ST_READY,
        ST_STORE
    } dpot_state_t;

    // Raw frame as left in the link domain at the end of a frame
    typedef struct packed {
        logic [4:0] edge_count;
        logic [15:0] bits;
    } dpot_raw_frame_t;

    // Decoded frame
    typedef struct packed {
        dpot_cmd_t command;
        logic channel_bit_high;
        logic channel_bit_low;
        logic [7:0] wiper_position_bits;
    } dpot_frame_t;

endpackage : dpot_pkg

// *** design/dpot_sync.sv ***
// Two flip-flop level synchroniser
`timescale 1ns/10ps
`include "dpot_defs.svh"

module dpot_sync
    import dpot_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Level in and out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // First stage is read only by the second
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_reg <= RST_VAL;
            sync_out <= RST_VAL;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : dpot_sync

// *** design/dpot_shift.sv ***
// Serial-clock domain shift register and edge counter
`timescale 1ns/10ps
`include "dpot_defs.svh"

module dpot_shift
    import dpot_pkg::*;
(
    // Serial pins, all in the serial clock domain
    input wire logic sclk,
    input wire logic select_n,
    input wire logic serial_din,
    // Frame left standing after select rises
    output dpot_raw_frame_t raw_frame
);

    logic fresh_reg;
    logic [4:0] count_reg;
    logic [15:0] shift_reg;

    // Marks the first edge of a frame; select high sets it at once, since
    // the serial clock stands still between frames
    always_ff @(posedge sclk or posedge select_n)
    begin
        if (select_n)
            fresh_reg <= 1'b1;
        else
            fresh_reg <= 1'b0;
    end

    // One bit per rising edge while selected, first bit ends highest; the
    // first edge drops what an earlier frame left, so no unknown bits linger
    always_ff @(posedge sclk)
    begin
        if (!select_n)
        begin
            if (fresh_reg)
                shift_reg <= {15'h0, serial_din};
            else
                shift_reg <= {shift_reg[14:0], serial_din};
        end
    end

    // Edge count, not cleared by select so the system side can read it
    always_ff @(posedge sclk)
    begin
        if (!select_n)
        begin
            if (fresh_reg)
                count_reg <= 5'd1;
            else if (count_reg != `DPOT_EDGE_MAX)
                count_reg <= count_reg + 5'd1;
        end
    end

    assign raw_frame = '{edge_count: count_reg, bits: shift_reg};

    AST_LINK_SHIFT: assert property (@(posedge sclk) disable iff (select_n)
        1'b1 |=> shift_reg == ($past(fresh_reg) ? {15'h0, $past(serial_din)}
            : {$past(shift_reg[14:0]), $past(serial_din)}))
        else $error("serial bit not shifted in");

    AST_LINK_FIRST_EDGE: assert property (@(posedge sclk) disable iff (select_n)
        fresh_reg |=> count_reg == 5'd1)
        else $error("frame edge count did not restart at one");

endmodule : dpot_shift

// *** test/dpot_host.sv ***
// Host model that drives select, serial clock and data toward the port
`timescale 1ns/10ps

module dpot_host
(
    // Serial pins toward the device
    output logic sclk,
    output logic select_n,
    output logic serial_din
);
    // Half of the 64 ns link clock
    localparam int HALF_NS = 32;

    // Idle levels; the serial clock stands still between frames
    initial
    begin
        sclk = 1'b0;
        serial_din = 1'b0;
        // Short low pulse at start: the link side has no reset, and the
        // rise of select is what gives its frame-start flag a known value
        select_n = 1'b0;
        #(1);
        select_n = 1'b1;
    end

    // Send the top n bits of word, first edge first, then release select
    task automatic send(input logic [15:0] word, input int n);
        int i;
        #(7);
        select_n = 1'b0;
        #(96);
        for (i = 0; i < n; i++)
        begin
            // Edges past the sixteenth carry zero, never an unknown bit
            serial_din = (i < 16) ? word[15 - i] : 1'b0;
            #(HALF_NS);
            sclk = 1'b1;
            #(HALF_NS);
            sclk = 1'b0;
            // Hold time over, so the line no longer shows the bit
            serial_din = ~serial_din;
        end
        #(HALF_NS);
        select_n = 1'b1;
        // Gap well above the least select high time
        #(288);
    endtask : send
endmodule : dpot_host

// *** test/dual_pot_serial_command_port_tb.sv ***
// Self-checking bench for the dual potentiometer serial command port
`timescale 1ns/10ps

module dual_pot_serial_command_port_tb
    import dpot_pkg::*;
;
    // Short busy count keeps the run brief
    localparam int BUSY = 100;
    localparam int LIMIT = 8000;

    // One table row: frame fields beside the wipers they should give
    typedef struct packed {
        dpot_cmd_t cmd;
        logic [1:0] chan;
        logic [7:0] data;
        logic [4:0] nbits;
        logic [7:0] exp_a;
        logic [7:0] exp_b;
        logic exp_busy;
    } dpot_row_t;

    localparam dpot_row_t ROWS [12] = '{
        '{DPOT_CMD_WR_WIPER, 2'h1, 8'h3c, 5'd16, 8'h3c, 8'h80, 1'b0},
        '{DPOT_CMD_WR_WIPER, 2'h2, 8'hff, 5'd16, 8'h3c, 8'hff, 1'b0},
        '{DPOT_CMD_WR_WIPER, 2'h3, 8'h00, 5'd16, 8'h00, 8'h00, 1'b0},
        '{DPOT_CMD_WR_NONVOLATILE, 2'h1, 8'h5a, 5'd16, 8'h00, 8'h00, 1'b1},
        '{DPOT_CMD_COPY_TO_WIPER, 2'h1, 8'h00, 5'd8, 8'h5a, 8'h00, 1'b0},
        '{DPOT_CMD_WR_WIPER, 2'h3, 8'hc3, 5'd16, 8'hc3, 8'hc3, 1'b0},
        '{DPOT_CMD_COPY_TO_NONVOLATILE, 2'h1, 8'h00, 5'd8, 8'hc3, 8'hc3, 1'b1},
        '{DPOT_CMD_COPY_TO_NONVOLATILE, 2'h2, 8'h77, 5'd16, 8'hc3, 8'hc3, 1'b1},
        '{DPOT_CMD_WR_NONVOLATILE, 2'h3, 8'h11, 5'd16, 8'hc3, 8'hc3, 1'b1},
        '{DPOT_CMD_COPY_TO_WIPER, 2'h2, 8'h00, 5'd8, 8'hc3, 8'h11, 1'b0},
        '{DPOT_CMD_WR_WIPER, 2'h1, 8'he7, 5'd16, 8'he7, 8'h11, 1'b0},
        '{DPOT_CMD_COPY_TO_WIPER, 2'h3, 8'hff, 5'd16, 8'h11, 8'h11, 1'b0}
    };

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic sclk;
    logic select_n;
    logic serial_din;
    logic [7:0] wiper_position_a;
    logic [7:0] wiper_position_b;
    logic store_busy;
    logic recall_done;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int busy_cnt = 0;
    int busy_len = 0;
    int r;

    // 50 ns system clock
    always #(25) clk = ~clk;

    dpot_top #(.STORE_BUSY_CYCLES(BUSY)) i_dut
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .sclk(sclk),
        .select_n(select_n),
        .serial_din(serial_din),
        .wiper_position_a(wiper_position_a),
        .wiper_position_b(wiper_position_b),
        .store_busy(store_busy),
        .recall_done(recall_done)
    );

    dpot_host i_host
    (
        .sclk(sclk),
        .select_n(select_n),
        .serial_din(serial_din)
    );

    // Length of the last busy stretch, taken when it ends
    always @(posedge clk)
    begin
        if (store_busy === 1'b1)
            busy_cnt <= busy_cnt + 1;
        else if (busy_cnt != 0)
        begin
            busy_len <= busy_cnt;
            busy_cnt <= 0;
        end
    end

    // Hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One whole frame, then wait for the answer to land
    task automatic run_frame(input dpot_cmd_t cmd, input logic [1:0] chan,
                             input logic [7:0] data, input int n);
        @(posedge clk);
        i_host.send({2'b00, cmd, 2'b00, chan, data}, n);
        @(posedge clk);
        #1;
    endtask : run_frame

    // Bounded wait until the store has finished
    task automatic wait_idle();
        int k;
        for (k = 0; k < BUSY + 20 && store_busy !== 1'b0; k++)
            @(posedge clk);
        repeat (2) @(posedge clk);
        #1;
    endtask : wait_idle

    task automatic do_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({15'h0, recall_done}, 16'h0000);
        chk({wiper_position_a, wiper_position_b}, 16'h0000);
        @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0, recall_done}, 16'h0001);
        chk({wiper_position_a, wiper_position_b}, 16'h8080);
    endtask : do_reset

    initial
    begin
        do_reset();
        // Table rows; stores are let finish before the next frame
        for (r = 0; r < 12; r++)
        begin
            run_frame(ROWS[r].cmd, ROWS[r].chan, ROWS[r].data, ROWS[r].nbits);
            chk({wiper_position_a, wiper_position_b},
                {ROWS[r].exp_a, ROWS[r].exp_b});
            chk({15'h0, store_busy}, {15'h0, ROWS[r].exp_busy});
            wait_idle();
            if (ROWS[r].exp_busy)
                chk(busy_len[15:0], BUSY[15:0]);
        end
        // Wrong edge counts for a write change nothing
        for (r = 0; r < 3; r++)
        begin
            run_frame(DPOT_CMD_WR_WIPER, 2'h1, 8'h42, (r == 0) ? 15 : (r == 1) ? 17 : 8);
            chk({wiper_position_a, wiper_position_b}, 16'h1111);
        end
        // Channel code 00 selects nothing
        run_frame(DPOT_CMD_WR_WIPER, 2'h0, 8'h42, 16);
        chk({wiper_position_a, wiper_position_b}, 16'h1111);
        // Frames sent on purpose while a store is running
        run_frame(DPOT_CMD_WR_NONVOLATILE, 2'h1, 8'h22, 16);
        chk({15'h0, store_busy}, 16'h0001);
        run_frame(DPOT_CMD_WR_WIPER, 2'h2, 8'h66, 16);
        chk({wiper_position_a, wiper_position_b}, 16'h1166);
        run_frame(DPOT_CMD_COPY_TO_NONVOLATILE, 2'h2, 8'h00, 8);
        run_frame(DPOT_CMD_WR_NONVOLATILE, 2'h2, 8'h99, 16);
        chk({15'h0, store_busy}, 16'h0001);
        wait_idle();
        run_frame(DPOT_CMD_COPY_TO_WIPER, 2'h3, 8'h00, 8);
        chk({wiper_position_a, wiper_position_b}, 16'h2211);
        // Wiper copied into its stored register, trailing data ignored
        run_frame(DPOT_CMD_WR_WIPER, 2'h1, 8'h3c, 16);
        run_frame(DPOT_CMD_COPY_TO_NONVOLATILE, 2'h1, 8'hff, 16);
        chk({15'h0, store_busy}, 16'h0001);
        wait_idle();
        chk(busy_len[15:0], BUSY[15:0]);
        run_frame(DPOT_CMD_WR_WIPER, 2'h1, 8'h00, 16);
        chk({wiper_position_a, wiper_position_b}, 16'h0011);
        run_frame(DPOT_CMD_COPY_TO_WIPER, 2'h1, 8'h00, 8);
        chk({wiper_position_a, wiper_position_b}, 16'h3c11);
        // Second reset at the end of the run recalls the 8'h80 reset values, not the written stores
        do_reset();
        close_out();
    end
endmodule : dual_pot_serial_command_port_tb
